// File: core/ldc_ctrl.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ldc_ctrl
   import ldc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [LDC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [LDC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_wake,
   input wire logic pin_a_in,
   input wire logic pin_b_in,
   output ldc_ladder_t ladder,
   output ldc_pin_ovr_t pin_a_ovr,
   output ldc_pin_ovr_t pin_b_ovr,
   output logic pin_a_read,
   output logic pin_b_read
);

   ////////////////////////////////////////////////////////////////////////////////
   // register state

   // control fields, one flop per implemented bit; bits 6 and 1 have none
   logic en_r, en_nxt;
   logic oe_a_r, oe_a_nxt;
   logic oe_b_r, oe_b_nxt;
   logic [1:0] pss_r, pss_nxt;
   logic nss_r, nss_nxt;
   // level code, the only field of the data register
   logic [4:0] code_r, code_nxt;

   // write channel state: address and data may arrive in either order
   logic aw_held_r, aw_held_nxt;
   logic [LDC_ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
   logic w_held_r, w_held_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic w_strb0_r, w_strb0_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   // read channel state: a single read is answered at a time
   logic rvalid_r, rvalid_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   // synchronised pin levels and write decode
   logic pin_a_sync, pin_b_sync;
   logic wr_go;
   logic wr_hit_ctrl, wr_hit_code;

   // decode one address against the register map
   // the full byte address is compared, so aliases of a register answer with an error
   function automatic logic addr_is(input logic [LDC_ADDR_W-1:0] a, input logic [LDC_ADDR_W-1:0] reg_addr);
      return a == reg_addr;
   endfunction

   // readback image of the control register, unimplemented bits 6 and 1 read zero
   function automatic logic [7:0] ctrl_image(input logic en, input logic oa, input logic ob,
                                              input logic [1:0] ps, input logic ns);
      logic [7:0] v;
      v = 8'h00;
      v[LDC_EN_BIT] = en;
      v[LDC_OE_A_BIT] = oa;
      v[LDC_OE_B_BIT] = ob;
      v[LDC_PSS_HI:LDC_PSS_LO] = ps;
      v[LDC_NSS_BIT] = ns;
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // write path

   // address and data are taken on their own handshakes and parked; once both are parked
   // the register is written and the answer raised on the same edge, so a write lands
   // one edge after the later handshake; the answer stands until the master takes it,
   // and no new write is taken meanwhile, which keeps one write in flight

   // ready is high while the clock is enabled, nothing of that channel is held and no response is pending
   assign s_axi_awready = ce && !aw_held_r && !bvalid_r;
   assign s_axi_wready = ce && !w_held_r && !bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   // commit when both halves are parked and no answer is pending
   assign wr_go = aw_held_r && w_held_r && !bvalid_r;
   assign wr_hit_ctrl = addr_is(aw_addr_r, LDC_CTRL_ADDR);
   assign wr_hit_code = addr_is(aw_addr_r, LDC_CODE_ADDR);

   // next values of write-side state and of the registers themselves
   always_comb begin
      aw_held_nxt = aw_held_r;
      aw_addr_nxt = aw_addr_r;
      w_held_nxt = w_held_r;
      w_data_nxt = w_data_r;
      w_strb0_nxt = w_strb0_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      en_nxt = en_r;
      oe_a_nxt = oe_a_r;
      oe_b_nxt = oe_b_r;
      pss_nxt = pss_r;
      nss_nxt = nss_r;
      code_nxt = code_r;
      // park the address until its data is in
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      // park the data and its lane-0 strobe
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb0_nxt = s_axi_wstrb[0];
      end
      // both halves parked: commit the write and raise the answer
      if (wr_go) begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = (wr_hit_ctrl || wr_hit_code) ? LDC_RESP_OKAY : LDC_RESP_SLVERR;
         // only byte lane 0 carries the 8-bit registers
         if (wr_hit_ctrl && w_strb0_r) begin
            en_nxt = w_data_r[LDC_EN_BIT];
            oe_a_nxt = w_data_r[LDC_OE_A_BIT];
            oe_b_nxt = w_data_r[LDC_OE_B_BIT];
            pss_nxt = w_data_r[LDC_PSS_HI:LDC_PSS_LO];
            nss_nxt = w_data_r[LDC_NSS_BIT];
         end
         if (wr_hit_code && w_strb0_r) begin
            code_nxt = w_data_r[LDC_CODE_W-1:0];
         end
      end
      // the master has taken the answer
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
   end

   // registers take only reset and bus writes; a wake from sleep is not a reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_r <= LDC_CTRL_RST[LDC_EN_BIT];
         oe_a_r <= LDC_CTRL_RST[LDC_OE_A_BIT];
         oe_b_r <= LDC_CTRL_RST[LDC_OE_B_BIT];
         pss_r <= LDC_CTRL_RST[LDC_PSS_HI:LDC_PSS_LO];
         nss_r <= LDC_CTRL_RST[LDC_NSS_BIT];
         code_r <= LDC_CODE_RST;
         // reset empties both parked halves and drops any pending answer
         aw_held_r <= 1'b0;
         aw_addr_r <= '0;
         w_held_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb0_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= LDC_RESP_OKAY;
      end else if (ce) begin
         // a low clock enable freezes every flop, bus state included
         en_r <= en_nxt;
         oe_a_r <= oe_a_nxt;
         oe_b_r <= oe_b_nxt;
         pss_r <= pss_nxt;
         nss_r <= nss_nxt;
         code_r <= code_nxt;
         aw_held_r <= aw_held_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_held_r <= w_held_nxt;
         w_data_r <= w_data_nxt;
         w_strb0_r <= w_strb0_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read path

   // the readback is captured at the address handshake, so a write committed on that
   // same edge shows only on the next read; unmapped addresses answer with an error
   // and zero data and touch no state

   // arready drops while an answer is pending, so reads never overlap
   assign s_axi_arready = ce && !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // one read in flight; data is captured at address acceptance
   always_comb begin
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = LDC_RESP_OKAY;
         if (addr_is(s_axi_araddr, LDC_CTRL_ADDR)) begin
            rdata_nxt = {24'h000000, ctrl_image(en_r, oe_a_r, oe_b_r, pss_r, nss_r)};
         end else if (addr_is(s_axi_araddr, LDC_CODE_ADDR)) begin
            rdata_nxt = {27'h0000000, code_r};
         end else begin
            rdata_nxt = 32'h0000_0000;
            rresp_nxt = LDC_RESP_SLVERR;
         end
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   // read channel registers, frozen with the clock enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rresp_r <= LDC_RESP_OKAY;
         rdata_r <= 32'h0000_0000;
      end else if (ce) begin
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // analog ladder and sleep wake

   // settings go straight from the registers, so a write shows one edge after it is taken;
   // the ladder forms vneg + span*code/32 itself, the code is passed unscaled;
   // reserved source code 11 is stored and passed on, the ladder treats it as no source
   always_comb begin
      ladder.enable = en_r;
      ladder.positive_source_select = pss_r;
      ladder.negative_source_select = nss_r;
      ladder.level_code = code_r;
   end

   // wake is accepted for completeness; it deliberately changes nothing, so the settings
   // survive sleep and software must clear the enable itself to save current
   logic unused_wake;
   assign unused_wake = sleep_wake;

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and overrides

   // pins are asynchronous to aclk; only the second flop of each pair is read
   ldc_sync2 u_sync_a (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .d(pin_a_in),
      .q(pin_a_sync)
   );

   ldc_sync2 u_sync_b (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .d(pin_b_in),
      .q(pin_b_sync)
   );

   // an enabled analog pin overrides its digital functions and masks its read
   ldc_pin_ovr u_pin_a (
      .out_enable(oe_a_r),
      .pin_in_sync(pin_a_sync),
      .ovr(pin_a_ovr),
      .pin_read(pin_a_read)
   );

   ldc_pin_ovr u_pin_b (
      .out_enable(oe_b_r),
      .pin_in_sync(pin_b_sync),
      .ovr(pin_b_ovr),
      .pin_read(pin_b_read)
   );

endmodule
`default_nettype wire

// File: core/ldc_pin_ovr.sv
`timescale 1ns/1ps
`default_nettype none
module ldc_pin_ovr
   import ldc_pkg::*;
(
   input wire logic out_enable,
   input wire logic pin_in_sync,
   output ldc_pin_ovr_t ovr,
   output logic pin_read
);
   // analog use of the pin forces off its digital functions
   always_comb begin
      ovr.analog_on = out_enable;
      ovr.digital_driver_off = out_enable;
      ovr.pullup_off = out_enable;
      ovr.input_detector_off = out_enable;
      pin_read = out_enable ? 1'b0 : pin_in_sync;
   end
endmodule
`default_nettype wire

// File: core/ldc_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module ldc_sync2 (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic d,
   output logic q
);
   logic s1_r;
   logic s1_nxt;
   logic q_nxt;
   // first stage is read only by the second
   always_comb begin
      s1_nxt = ce ? d : s1_r;
      q_nxt = ce ? s1_r : q;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= 1'b0;
         q <= 1'b0;
      end else begin
         s1_r <= s1_nxt;
         q <= q_nxt;
      end
   end
endmodule
`default_nettype wire

// File: dv/ldc_ladder_model.sv
`timescale 1ns/1ps
`default_nettype none
module ldc_ladder_model
   import ldc_pkg::*;
#(
   parameter int SUP_MV = 3300,
   parameter int EXTP_MV = 2048,
   parameter int BUF_MV = 1024,
   parameter int EXTN_MV = 500
)
(
   input wire ldc_ladder_t ladder,
   output var int level_mv
);
   int p;
   int n;
   // tap of the ladder in millivolts; a powered-down or reserved ladder gives none
   always_comb begin
      p = ladder.positive_source_select[1] ? BUF_MV : (ladder.positive_source_select[0] ? EXTP_MV : SUP_MV);
      n = ladder.negative_source_select ? EXTN_MV : 0;
      level_mv = n + (p - n) * int'(ladder.level_code) / 32;
      if (!ladder.enable || ladder.positive_source_select == LDC_PSS_RSVD) level_mv = 0;
   end
endmodule
`default_nettype wire

// File: dv/ldc_props.sv
`timescale 1ns/1ps
`default_nettype none
module ldc_props
   import ldc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire ldc_ladder_t ladder,
   input wire ldc_pin_ovr_t pin_a_ovr,
   input wire ldc_pin_ovr_t pin_b_ovr,
   input wire logic pin_a_read,
   input wire logic pin_b_read
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////
   // both write channels taken on one edge, answer after one idle cycle
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence wr_answer;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   rst_clear_a: assert property ($rose(aresetn) |-> ladder == 9'h0 && pin_a_ovr == 4'h0 && pin_b_ovr == 4'h0)
      else $error("outputs not cleared by reset");
   // past reset term skips the edge right after a release
   out_hold_a: assert property ($past(aresetn) && $changed({ladder, pin_a_ovr, pin_b_ovr}) |-> $rose(s_axi_bvalid))
      else $error("outputs moved without a write");
   pin_force_a: assert property (pin_a_ovr == {4{pin_a_ovr.analog_on}} && pin_b_ovr == {4{pin_b_ovr.analog_on}})
      else $error("pin override fields disagree");
   pin_a_zero_a: assert property (pin_a_ovr.analog_on |-> !pin_a_read)
      else $error("analog pin a reads one");
   pin_b_zero_a: assert property (pin_b_ovr.analog_on |-> !pin_b_read)
      else $error("analog pin b reads one");
   wr_answer_a: assert property (wr_taken |=> wr_answer)
      else $error("write answer mistimed");
   wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while answering");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
endmodule
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
   import ldc_pkg::*;
;
   logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, sleep_wake = 1'h0, pin_a_in = 1'h0, pin_b_in = 1'h0;
   logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
   // ready lines stay high, which the bus allows for the answer channels
   logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, k;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pin_a_read, pin_b_read;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] c;
   ldc_ladder_t ladder;
   ldc_pin_ovr_t pin_a_ovr, pin_b_ovr;
   int level_mv, num_errors = 0, compares = 0, cyc = 0, i;
   ldc_ctrl i_ldc_ctrl (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .sleep_wake(sleep_wake), .pin_a_in(pin_a_in), .pin_b_in(pin_b_in), .ladder(ladder),
      .pin_a_ovr(pin_a_ovr), .pin_b_ovr(pin_b_ovr), .pin_a_read(pin_a_read), .pin_b_read(pin_b_read)
   );
   ldc_ladder_model i_ldc_ladder_model (.ladder(ladder), .level_mv(level_mv));
   always #5 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////////
   // a hung handshake would otherwise stall the run forever
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         $display("[ERR] %0t timeout", $time);
         complete_run();
      end
   end
   task automatic complete_run();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // both channels offered together, each dropped on its own handshake
   task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] r);
      logic ad;
      logic wd;
      ad = 1'h0;
      wd = 1'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'($urandom), d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         ad = ad | (s_axi_awready === 1'h1);
         wd = wd | (s_axi_wready === 1'h1);
         if (ad) s_axi_awvalid <= 1'h0;
         if (wd) s_axi_wvalid <= 1'h0;
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
      chk(32'(s_axi_bresp), 32'(r));
   endtask
   task automatic rd(input logic [13:0] a, input logic [31:0] e, input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge aclk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
      chk(s_axi_rdata, e);
      chk(32'(s_axi_rresp), 32'(r));
   endtask
   // expected tap in millivolts from the control byte and the code
   function automatic int exp_level(input logic [7:0] cc, input logic [4:0] kk);
      int p;
      int n;
      p = cc[3] ? 1024 : (cc[2] ? 2048 : 3300);
      n = cc[0] ? 500 : 0;
      return (cc[7] && cc[3:2] != 2'h3) ? n + (p - n) * int'(kk) / 32 : 0;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h9a7c3868));
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      chk(32'({ladder, pin_a_ovr, pin_b_ovr}), 32'h0);
      rd(LDC_CTRL_ADDR, 32'h0, LDC_RESP_OKAY);
      rd(LDC_CODE_ADDR, 32'h0, LDC_RESP_OKAY);
      // first four passes walk every source code with code ends, the rest are random
      for (i = 0; i < 24; i++) begin
         c = (i < 4) ? 8'hb1 | 8'(i << 2) : 8'($urandom);
         k = (i < 4) ? 32'(i[0]) * 32'h1f : $urandom;
         wr(LDC_CTRL_ADDR, c, 4'h1, LDC_RESP_OKAY);
         wr(LDC_CODE_ADDR, k[7:0], 4'hf, LDC_RESP_OKAY);
         rd(LDC_CTRL_ADDR, 32'(c & 8'hbd), LDC_RESP_OKAY);
         rd(LDC_CODE_ADDR, 32'(k[4:0]), LDC_RESP_OKAY);
         chk(32'(ladder), 32'({c[7], c[3:2], c[0], k[4:0]}));
         chk(32'({pin_a_ovr, pin_b_ovr}), 32'({{4{c[5]}}, {4{c[4]}}}));
         chk(32'(level_mv), 32'(exp_level(c, k[4:0])));
         pin_a_in <= 1'($urandom);
         pin_b_in <= 1'($urandom);
         repeat (4) @(posedge aclk);
         chk(32'({pin_a_read, pin_b_read}), 32'({pin_a_in & ~c[5], pin_b_in & ~c[4]}));
      end
      wr(LDC_CTRL_ADDR, 8'h00, 4'h0, LDC_RESP_OKAY);
      wr(14'h0004, 8'hff, 4'h1, LDC_RESP_SLVERR);
      rd(14'h0004, 32'h0, LDC_RESP_SLVERR);
      sleep_wake <= 1'h1;
      @(posedge aclk);
      sleep_wake <= 1'h0;
      rd(LDC_CTRL_ADDR, 32'(c & 8'hbd), LDC_RESP_OKAY);
      wr(LDC_CTRL_ADDR, c & 8'h7f, 4'h1, LDC_RESP_OKAY);
      chk(32'(ladder.enable), 32'h0);
      chk(32'(level_mv), 32'h0);
      // a low clock enable refuses every request and holds the settings
      ce <= 1'h0;
      repeat (2) @(posedge aclk);
      chk(32'({s_axi_awready, s_axi_wready, s_axi_arready}), 32'h0);
      chk(32'(ladder), 32'({1'b0, c[3:2], c[0], k[4:0]}));
      ce <= 1'h1;
      // reset in mid-run with the pins and the code in use
      wr(LDC_CODE_ADDR, 8'h1f, 4'h1, LDC_RESP_OKAY);
      wr(LDC_CTRL_ADDR, 8'hb0, 4'h1, LDC_RESP_OKAY);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      chk(32'({ladder, pin_a_ovr, pin_b_ovr}), 32'h0);
      rd(LDC_CODE_ADDR, 32'h0, LDC_RESP_OKAY);
      complete_run();
   end
endmodule
bind ldc_ctrl ldc_props i_ldc_props (
   .aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
   .ladder(ladder), .pin_a_ovr(pin_a_ovr), .pin_b_ovr(pin_b_ovr),
   .pin_a_read(pin_a_read), .pin_b_read(pin_b_read)
);
`default_nettype wire

// File: inc/ldc_pkg.sv
package ldc_pkg;
   // register indices as printed (not multiples of four), byte address is four times the index
   localparam logic [11:0] LDC_CTRL_IDX = 12'hf2e;
   localparam logic [11:0] LDC_CODE_IDX = 12'hf2f;
   localparam logic [13:0] LDC_CTRL_ADDR = {LDC_CTRL_IDX, 2'b00};
   localparam logic [13:0] LDC_CODE_ADDR = {LDC_CODE_IDX, 2'b00};
   localparam int LDC_ADDR_W = 14;
   // control field positions
   localparam int LDC_EN_BIT = 7;
   localparam int LDC_OE_A_BIT = 5;
   localparam int LDC_OE_B_BIT = 4;
   localparam int LDC_PSS_HI = 3;
   localparam int LDC_PSS_LO = 2;
   localparam int LDC_NSS_BIT = 0;
   localparam int LDC_CODE_W = 5;
   localparam logic [7:0] LDC_CTRL_RST = 8'h00;
   localparam logic [4:0] LDC_CODE_RST = 5'h00;
   // positive source encodings
   localparam logic [1:0] LDC_PSS_SUPPLY = 2'h0;
   localparam logic [1:0] LDC_PSS_EXTREF = 2'h1;
   localparam logic [1:0] LDC_PSS_BUFFER = 2'h2;
   localparam logic [1:0] LDC_PSS_RSVD = 2'h3;
   localparam logic [1:0] LDC_RESP_OKAY = 2'h0;
   localparam logic [1:0] LDC_RESP_SLVERR = 2'h2;

   // settings presented to the analog ladder
   typedef struct packed {
      logic enable;
      logic [1:0] positive_source_select;
      logic negative_source_select;
      logic [4:0] level_code;
   } ldc_ladder_t;

   // per-pin override to the port logic
   typedef struct packed {
      logic analog_on;
      logic digital_driver_off;
      logic pullup_off;
      logic input_detector_off;
   } ldc_pin_ovr_t;
endpackage
